// ==== rtl/host_irq_enable_and_id.sv ====
// Purpose: Processor interrupt enable register, interrupt request gating,
//   start-of-frame suppression in suspend, and silicon identity register
// Assumes: Command port is driven by logic on mclk_i, one command a cycle
// Notes: Read data appears one cycle after the read command
//
// Operation
// R1: Enable bit 6 lets the clock-ready flag drive the interrupt request.
// R2: Enable bit 5 lets the host-suspended flag drive the interrupt request.
// R3: Processor suspends the controller by writing the host control register; here suspend is a direct input, all_ports_suspended_i.
// R4: No start-of-frame is emitted while all downstream devices are suspended.
// R5: Enable bit 4 gates the operational register event interrupt.
// R6: Enable bit 2 gates the end-of-transfer interrupt.
// R7: Enable bit 1 gates the asynchronous-list interrupt.
// R8: Enable bit 0 gates the start-of-frame interrupt.
// R9: On start-of-frame, DMA reads DMA config first, then isochronous data.
// R10: Identity register is 16-bit, read-only, read by command 27 hex.
// R11: Identity upper byte is the product, lower byte the revision.
// R12: Identity bit 0 is 0 on original and 1 on improved variants.
// R13: All enables reset to zero so no interrupt request is raised.
// R14: Each enable masks its flag; global enable bit gates the pin.
// R15: Enable register read by command 25 hex, written by A5 hex.
// R16: Reserved enable bits read zero and ignore writes.

`timescale 1ns/1ps
`default_nettype none

module host_irq_enable_and_id #(
  // Arbitrary identity values, not those of any real part
  parameter logic [7:0] PRODUCT_CODE = 8'h5A,
  parameter logic [7:0] REVISION_CODE = 8'h10,
  parameter bit IMPROVED_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Register command port
  input wire logic cmd_valid_i,
  input wire logic [host_irq_pkg::CMD_W-1:0] cmd_code_i,
  input wire logic [host_irq_pkg::DATA_W-1:0] wr_data_i,
  output logic rd_valid_o,
  output logic [host_irq_pkg::DATA_W-1:0] rd_data_o,
  // Interrupt sources and global enable
  input wire logic [host_irq_pkg::SRC_W-1:0] irq_flags_i,
  input wire logic [host_irq_pkg::DATA_W-1:0] hw_config_reg_i,
  output logic irq_o,
  output logic [host_irq_pkg::DATA_W-1:0] irq_enable_o,
  // Start-of-frame gating
  input wire logic sof_tick_i,
  input wire logic all_ports_suspended_i,
  output logic sof_emit_o
);
  import host_irq_pkg::*;

  logic [DATA_W-1:0] cpu_interrupt_enable_reg;
  logic [DATA_W-1:0] silicon_identity_value;
  logic [DATA_W-1:0] next_rd_data;
  logic [SRC_W-1:0] masked_flags;
  logic is_read;
  logic is_en_write;
  logic global_irq_en;

  // Decoding used by the write path, read path and checks
  function automatic logic cmd_is_write(input logic [CMD_W-1:0] code);
    return code[CMD_WRITE_BIT];
  endfunction

  assign is_read = cmd_valid_i && !cmd_is_write(cmd_code_i);
  assign is_en_write = cmd_valid_i && (cmd_code_i == CMD_IRQ_EN_WR); // [R15]

  // Identity is a constant; bit 0 tells the variant apart
  always_comb begin
    silicon_identity_value = {PRODUCT_CODE, REVISION_CODE}; // [R11]
    silicon_identity_value[ID_VARIANT_BIT] = IMPROVED_VARIANT; // [R12]
  end

  // Enable register; reserved bits never store
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cpu_interrupt_enable_reg <= IRQ_EN_RESET; // [R13]
    end else if (is_en_write) begin
      cpu_interrupt_enable_reg <= wr_data_i & IRQ_EN_MASK; // [R16]
    end
  end

  assign irq_enable_o = cpu_interrupt_enable_reg;

  // Read path, unknown read codes answer zero
  always_comb begin
    next_rd_data = RD_IDLE;
    if (is_read) begin
      unique case (cmd_code_i)
        CMD_IRQ_EN_RD: next_rd_data = cpu_interrupt_enable_reg; // [R15]
        CMD_ID_RD: next_rd_data = silicon_identity_value; // [R10]
        default: next_rd_data = RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= RD_IDLE;
    end else begin
      rd_valid_o <= is_read;
      rd_data_o <= next_rd_data;
    end
  end

  // Each enable masks the flag in the same position
  always_comb begin
    masked_flags = irq_flags_i & cpu_interrupt_enable_reg[SRC_W-1:0]; // [R14]
    masked_flags[3] = 1'b0; // [R16]
  end

  assign global_irq_en = hw_config_reg_i[HWCFG_GLOBAL_IRQ_BIT];

  // Registered so the pin is glitch free; one cycle of latency
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0; // [R13]
    end else begin
      irq_o <= global_irq_en && (|masked_flags); // [R14]
    end
  end

  // Suspend arrives directly on all_ports_suspended_i, not through host control writes;
  // here the frame marker is simply held back while all ports sleep
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sof_emit_o <= 1'b0;
    end else begin
      sof_emit_o <= sof_tick_i && !all_ports_suspended_i; // [R4] [R3]
    end
  end

  // Checks
  sequence s_en_write(int unsigned pos);
    is_en_write && wr_data_i[pos];
  endsequence

  sequence s_flag_alone(int unsigned pos);
    global_irq_en && irq_flags_i == SRC_W'(1 << pos);
  endsequence

  property p_source_enabled(int unsigned pos);
    @(posedge mclk_i) disable iff (srst_i)
      (cpu_interrupt_enable_reg[pos] and s_flag_alone(pos)) |=> irq_o;
  endproperty

  property p_source_masked(int unsigned pos);
    @(posedge mclk_i) disable iff (srst_i)
      (!cpu_interrupt_enable_reg[pos] and s_flag_alone(pos)) |=> !irq_o;
  endproperty

  AST_CLK_READY_EN: assert property (p_source_enabled(EN_CLK_READY)) // [R1]
    else $error("clock ready enable did not raise irq");
  AST_SUSPENDED_EN: assert property (p_source_enabled(EN_SUSPENDED)) // [R2]
    else $error("suspended enable did not raise irq");
  AST_OPREG_EN: assert property (p_source_enabled(EN_OPREG)) // [R5]
    else $error("opreg enable did not raise irq");
  AST_XFER_DONE_EN: assert property (p_source_enabled(EN_XFER_DONE)) // [R6]
    else $error("transfer done enable did not raise irq");
  AST_ASYNC_LIST_EN: assert property (p_source_enabled(EN_ASYNC_LIST)) // [R7]
    else $error("async list enable did not raise irq");
  AST_SOF_MASKED: assert property (p_source_masked(EN_SOF)) // [R8]
    else $error("masked sof flag raised irq");

  AST_ENABLE_STORE: assert property (@(posedge mclk_i) disable iff (srst_i)
      s_en_write(EN_SOF) |=> cpu_interrupt_enable_reg[EN_SOF]) // [R8]
    else $error("sof enable write not stored");

  AST_GLOBAL_GATE: assert property (@(posedge mclk_i) disable iff (srst_i)
      !global_irq_en |=> !irq_o) // [R14]
    else $error("irq raised with global enable off");

  AST_RESET_CLEAR: assert property (@(posedge mclk_i)
      srst_i |=> (cpu_interrupt_enable_reg == IRQ_EN_RESET) && !irq_o) // [R13]
    else $error("enables not cleared by reset");

  AST_RESERVED_ZERO: assert property (@(posedge mclk_i) disable iff (srst_i)
      (cpu_interrupt_enable_reg & ~IRQ_EN_MASK) == RD_IDLE) // [R16]
    else $error("reserved enable bit set");

  AST_ID_READ: assert property (@(posedge mclk_i) disable iff (srst_i)
      (cmd_valid_i && cmd_code_i == CMD_ID_RD) |=>
      rd_valid_o && rd_data_o[15:ID_PRODUCT_LSB] == PRODUCT_CODE) // [R10]
    else $error("identity read returned wrong product");

  AST_ID_VARIANT: assert property (@(posedge mclk_i) disable iff (srst_i)
      (cmd_valid_i && cmd_code_i == CMD_ID_RD) |=>
      rd_data_o[ID_VARIANT_BIT] == IMPROVED_VARIANT) // [R12]
    else $error("identity variant bit wrong");

  AST_EN_READBACK: assert property (@(posedge mclk_i) disable iff (srst_i)
      (cmd_valid_i && cmd_code_i == CMD_IRQ_EN_RD) |=>
      rd_data_o == $past(cpu_interrupt_enable_reg)) // [R15]
    else $error("enable readback mismatch");

  AST_SOF_HELD: assert property (@(posedge mclk_i) disable iff (srst_i)
      all_ports_suspended_i |=> !sof_emit_o) // [R4]
    else $error("sof emitted while all ports suspended");

  AST_SOF_PASS: assert property (@(posedge mclk_i) disable iff (srst_i)
      (sof_tick_i && !all_ports_suspended_i) |=> sof_emit_o) // [R4]
    else $error("sof tick dropped while active");

  AST_SOF_QUIET: assert property (@(posedge mclk_i) disable iff (srst_i)
      !sof_tick_i |=> !sof_emit_o) // [R4]
    else $error("sof emitted without a tick");

  AST_SOF_EN: assert property (p_source_enabled(EN_SOF)) // [R8]
    else $error("sof enable did not raise irq");
  AST_CLK_READY_MASKED: assert property (p_source_masked(EN_CLK_READY)) // [R1]
    else $error("masked clock ready flag raised irq");
  AST_SUSPENDED_MASKED: assert property (p_source_masked(EN_SUSPENDED)) // [R2]
    else $error("masked suspended flag raised irq");
  AST_OPREG_MASKED: assert property (p_source_masked(EN_OPREG)) // [R5]
    else $error("masked opreg flag raised irq");
  AST_XFER_DONE_MASKED: assert property (p_source_masked(EN_XFER_DONE)) // [R6]
    else $error("masked transfer done flag raised irq");
  AST_ASYNC_MASKED: assert property (p_source_masked(EN_ASYNC_LIST)) // [R7]
    else $error("masked async list flag raised irq");

  // Bit 3 has no source behind it, whatever software wrote
  AST_RESERVED_FLAG: assert property (@(posedge mclk_i) disable iff (srst_i)
      s_flag_alone(3) |=> !irq_o) // [R16]
    else $error("reserved flag raised irq");

  AST_IRQ_FOLLOW: assert property (@(posedge mclk_i) disable iff (srst_i)
      (global_irq_en && (|masked_flags)) |=> irq_o) // [R14]
    else $error("enabled pending flag did not raise irq");

  AST_IRQ_QUIET: assert property (@(posedge mclk_i) disable iff (srst_i)
      !(|masked_flags) |=> !irq_o) // [R14]
    else $error("irq raised with nothing pending");

  // Every live bit takes exactly what was written, set or clear
  property p_store(int unsigned pos);
    @(posedge mclk_i) disable iff (srst_i)
      is_en_write |=> cpu_interrupt_enable_reg[pos] == $past(wr_data_i[pos]);
  endproperty

  AST_STORE_CLK_READY: assert property (p_store(EN_CLK_READY)) // [R1]
    else $error("clock ready enable not stored");
  AST_STORE_SUSPENDED: assert property (p_store(EN_SUSPENDED)) // [R2]
    else $error("suspended enable not stored");
  AST_STORE_OPREG: assert property (p_store(EN_OPREG)) // [R5]
    else $error("opreg enable not stored");
  AST_STORE_XFER_DONE: assert property (p_store(EN_XFER_DONE)) // [R6]
    else $error("transfer done enable not stored");
  AST_STORE_ASYNC: assert property (p_store(EN_ASYNC_LIST)) // [R7]
    else $error("async list enable not stored");
  AST_STORE_SOF: assert property (p_store(EN_SOF)) // [R8]
    else $error("sof enable not stored");

  AST_ENABLE_HOLD: assert property (@(posedge mclk_i) disable iff (srst_i)
      !is_en_write |=> $stable(cpu_interrupt_enable_reg)) // [R15]
    else $error("enable register changed without a write");

  // The write form of the identity code must not reach the enables
  AST_ID_NO_WRITE: assert property (@(posedge mclk_i) disable iff (srst_i)
      (cmd_valid_i && cmd_code_i == (CMD_ID_RD | 8'h80)) |=>
      $stable(cpu_interrupt_enable_reg)) // [R10]
    else $error("identity write code altered enables");

  AST_ID_REVISION: assert property (@(posedge mclk_i) disable iff (srst_i)
      (cmd_valid_i && cmd_code_i == CMD_ID_RD) |=>
      rd_data_o[ID_PRODUCT_LSB-1:1] == REVISION_CODE[7:1]) // [R11]
    else $error("identity read returned wrong revision");

  AST_UNKNOWN_READ: assert property (@(posedge mclk_i) disable iff (srst_i)
      (is_read && cmd_code_i != CMD_IRQ_EN_RD && cmd_code_i != CMD_ID_RD)
      |=> rd_valid_o && rd_data_o == RD_IDLE) // [R15]
    else $error("unknown read code returned data");

  AST_RD_IDLE: assert property (@(posedge mclk_i) disable iff (srst_i)
      !is_read |=> !rd_valid_o && rd_data_o == RD_IDLE) // [R15]
    else $error("read answer without a read command");

  AST_RESET_OUTPUTS: assert property (@(posedge mclk_i)
      srst_i |=> !rd_valid_o && !sof_emit_o && rd_data_o == RD_IDLE) // [R13]
    else $error("outputs not quiet after reset");

  // A read right behind a write sees the new value
  sequence s_en_write_any;
    is_en_write;
  endsequence

  sequence s_en_read;
    cmd_valid_i && cmd_code_i == CMD_IRQ_EN_RD;
  endsequence

  AST_WR_THEN_RD: assert property (@(posedge mclk_i) disable iff (srst_i)
      (s_en_write_any ##1 s_en_read) |=>
      rd_data_o == ($past(wr_data_i, 2) & IRQ_EN_MASK)) // [R15]
    else $error("read after write missed the new value");

endmodule // host_irq_enable_and_id

`default_nettype wire

// ==== rtl/host_irq_pkg.sv ====
// Purpose: Shared constants for the interrupt enable and identity block
// Assumes: 8-bit command codes, 16-bit register data
// Notes: Command bit 7 set marks a write code

package host_irq_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned CMD_W = 8;
  localparam int unsigned SRC_W = 7;

  // Command codes
  localparam logic [CMD_W-1:0] CMD_IRQ_EN_RD = 8'h25;
  localparam logic [CMD_W-1:0] CMD_IRQ_EN_WR = 8'hA5;
  localparam logic [CMD_W-1:0] CMD_ID_RD = 8'h27;
  localparam int unsigned CMD_WRITE_BIT = 7;

  // Enable field positions
  localparam int unsigned EN_SOF = 0;
  localparam int unsigned EN_ASYNC_LIST = 1;
  localparam int unsigned EN_XFER_DONE = 2;
  localparam int unsigned EN_OPREG = 4;
  localparam int unsigned EN_SUSPENDED = 5;
  localparam int unsigned EN_CLK_READY = 6;

  // Writable bits 6:4 and 2:0; the rest read as zero
  localparam logic [DATA_W-1:0] IRQ_EN_MASK = 16'h0077;
  localparam logic [DATA_W-1:0] IRQ_EN_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] RD_IDLE = 16'h0000;

  // Identity fields: product in the upper byte, revision below
  localparam int unsigned ID_PRODUCT_LSB = 8;
  localparam int unsigned ID_VARIANT_BIT = 0;

  // Global interrupt enable position in the hardware config register
  localparam int unsigned HWCFG_GLOBAL_IRQ_BIT = 0;

endpackage

// ==== tb/host_cpu_model.sv ====
// Purpose: Host processor model driving the register command port
// Assumes: Commands launched just after rising edges of mclk_i
// Notes: Released data lines carry the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
  // Clock
  input wire logic mclk_i,
  // Command port and suspend state
  output logic cmd_valid_o = 1'b0,
  output logic [7:0] cmd_code_o = 8'h00,
  output logic [15:0] wr_data_o = 16'h0000,
  output logic suspend_o = 1'b0
);
  task automatic send(input logic [7:0] c, input logic [15:0] d);
    @(posedge mclk_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o <= c;
    wr_data_o <= d;
    @(posedge mclk_i);
    cmd_valid_o <= 1'b0;
    wr_data_o <= ~d;
  endtask
  // Frame interrupt service order is the firmware's duty
  // Suspend is driven straight from the suspend task, with no control register write
  task automatic suspend(input logic s);
    @(posedge mclk_i);
    suspend_o <= s;
  endtask
endmodule // host_cpu_model
`default_nettype wire

// ==== tb/test_host_irq_enable_and_id.sv ====
// Purpose: Self-checking bench for the enable and identity block
// Assumes: Read answer one cycle after the command edge
// Notes: Identity parameters are arbitrary, not those of a real part
`timescale 1ns/1ps
`default_nettype none
module test_host_irq_enable_and_id;
  import host_irq_pkg::*;
  typedef struct packed {
    logic [15:0] en;
    logic [6:0] fl;
    logic g;
    logic ex;
  } row_t;
  localparam row_t ROWS [9] = '{
    '{16'h0040, 7'h40, 1'b1, 1'b1}, '{16'h0020, 7'h20, 1'b1, 1'b1},
    '{16'h0010, 7'h10, 1'b1, 1'b1}, '{16'h0004, 7'h04, 1'b1, 1'b1},
    '{16'h0002, 7'h02, 1'b1, 1'b1}, '{16'h0001, 7'h01, 1'b1, 1'b1},
    '{16'h0001, 7'h01, 1'b0, 1'b0}, '{16'hFFBE, 7'h41, 1'b1, 1'b0},
    '{16'h0008, 7'h08, 1'b1, 1'b0}};
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid, rd_valid, irq, sof_emit, susp;
  logic [7:0] cmd_code;
  logic [15:0] wr_data, rd_data, irq_en;
  logic [6:0] flags = 7'h00;
  logic [15:0] hwcfg = 16'h0000;
  logic sof_tick = 1'b0;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  always #12.5 mclk = ~mclk;
  host_cpu_model cpu (.mclk_i(mclk), .cmd_valid_o(cmd_valid),
    .cmd_code_o(cmd_code), .wr_data_o(wr_data), .suspend_o(susp));
  // Arbitrary identity values
  host_irq_enable_and_id #(.PRODUCT_CODE(8'hC3), .REVISION_CODE(8'h10),
    .IMPROVED_VARIANT(1'b1)) dut (.mclk_i(mclk), .srst_i(srst),
    .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .wr_data_i(wr_data),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data), .irq_flags_i(flags),
    .hw_config_reg_i(hwcfg), .irq_o(irq), .irq_enable_o(irq_en),
    .sof_tick_i(sof_tick), .all_ports_suspended_i(susp),
    .sof_emit_o(sof_emit));
  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] exp);
    cpu.send(c, 16'h0000);
    #1;
    check("rd_valid", rd_valid, 1'b1);
    check("rd_data", rd_data, exp);
    @(posedge mclk);
    #1;
    check("rd_valid_end", rd_valid, 1'b0);
    check("rd_data_end", rd_data, 16'h0000);
  endtask
  task automatic report_and_stop();
    $display("TB: %0d compared, %0d failed", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Whole run needs about 90 cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    #1;
    check("en_rst", irq_en, 16'h0000);
    check("irq_rst", irq, 1'b0);
    check("rdv_rst", rd_valid, 1'b0);
    $display("TB: reset test done");
    foreach (ROWS[i]) begin
      cpu.send(CMD_IRQ_EN_WR, ROWS[i].en);
      flags <= ROWS[i].fl;
      hwcfg <= {15'h0000, ROWS[i].g};
      repeat (2) @(posedge mclk);
      #1;
      check("irq", irq, ROWS[i].ex);
      rd(CMD_IRQ_EN_RD, ROWS[i].en & 16'h0077);
    end
    $display("TB: row tests done");
    cpu.send(8'hA7, 16'hFFFF);
    rd(CMD_ID_RD, 16'hC311);
    rd(CMD_IRQ_EN_RD, 16'h0000);
    rd(8'h28, 16'h0000);
    $display("TB: identity test done");
    for (int s = 0; s < 2; s++) begin
      cpu.suspend(s[0]);
      sof_tick <= 1'b1;
      @(posedge mclk);
      sof_tick <= 1'b0;
      #1;
      check("sof", sof_emit, (s == 0));
    end
    $display("TB: frame marker test done");
    // Reset with every source pending must still silence the request
    cpu.send(CMD_IRQ_EN_WR, 16'h0077);
    flags <= 7'h7F;
    @(posedge mclk);
    #1;
    check("irq_pre", irq, 1'b1);
    @(posedge mclk);
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    #1;
    check("en_rerst", irq_en, 16'h0000);
    check("irq_rerst", irq, 1'b0);
    @(posedge mclk);
    #1;
    check("irq_after", irq, 1'b0);
    $display("TB: second reset test done");
    report_and_stop();
  end
endmodule // test_host_irq_enable_and_id
`default_nettype wire
